// [core/nm_cfg_pkg.sv]
// Constants, field positions and types of the network master start-up block.
// Assumes a single 100 MHz clock and an object-dictionary style access port.
package nm_cfg_pkg;

  localparam logic [15:0] IDX_STARTUP = 16'h1F80;
  localparam logic [15:0] IDX_ASSIGN = 16'h1F81;
  localparam logic [15:0] IDX_STORE = 16'h1010;
  localparam logic [7:0] SUB_STORE_ALL = 8'h01;
  localparam logic [31:0] STORE_SIGNATURE = 32'h65766173;
  localparam logic [7:0] NODE_COUNT = 8'h7F;

  localparam int SU_MASTER = 0;
  localparam int SU_START_ALL = 1;
  localparam int SU_NO_AUTO_OP = 2;
  localparam int SU_NO_START = 3;
  localparam int SU_RESET_ALL = 4;
  localparam int SU_STOP_ALL = 6;
  localparam logic [31:0] STARTUP_MASK = 32'h0000005F;
  localparam logic [31:0] STARTUP_RESET = 32'h00000000;

  localparam int SA_SLAVE = 0;
  localparam int SA_BOOT = 2;
  localparam int SA_MANDATORY = 3;
  localparam int SA_RESTORE = 7;
  localparam int SA_RETRY_LSB = 8;
  localparam int SA_INTERVAL_LSB = 16;
  localparam logic [31:0] ASSIGN_MASK = 32'hFFFFFF8D;
  localparam logic [31:0] ASSIGN_RESET = 32'h00000000;

  // One guard interval unit is one millisecond
  localparam int GUARD_UNIT_NS = 1000000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int GUARD_UNIT_CYCLES = GUARD_UNIT_NS / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    GS_IDLE = 4'b0001,
    GS_SEND = 4'b0010,
    GS_WAIT = 4'b0100,
    GS_FAIL = 4'b1000
  } guard_state_t;

endpackage

// [core/nm_store.sv]
// Non-volatile copy of the start-up word; loaded into the live word one cycle after reset.
// Assumes the store signature is written by software to the store object.
`timescale 1ns/1ps
`default_nettype none
module nm_store (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // Store request and value
  input wire logic store_i,
  input wire logic [31:0] live_i,
  output logic [31:0] saved_o
);

  typedef struct packed {
    logic [31:0] saved;
  } store_st_t;

  store_st_t s_q;
  store_st_t s_d;

  always_comb begin
    s_d = s_q;
    if (store_i) begin
      s_d.saved = live_i & nm_cfg_pkg::STARTUP_MASK;
    end
  end

  // Saved copy models flash: it is not cleared by the system reset
  always_ff @(posedge ref_clk_i) begin
    if (clk_en_i) begin
      s_q <= s_d;
    end
  end

  assign saved_o = s_q.saved;

endmodule
`default_nettype wire

// [core/nm_guard.sv]
// Guarding timer of one slave: issues requests and counts missed replies.
// Assumes replies arrive as one-cycle pulses from the protocol engine.
`timescale 1ns/1ps
`default_nettype none
module nm_guard (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // Control
  input wire logic enable_i,
  input wire logic [7:0] retry_i,
  input wire logic [15:0] interval_i,
  input wire logic reply_i,
  // Outputs
  output logic request_o,
  output logic fail_o
);

  typedef struct packed {
    nm_cfg_pkg::guard_state_t st;
    logic [7:0] tries;
    logic [15:0] units;
    logic [23:0] tick;
  } guard_st_t;

  guard_st_t g_q;
  guard_st_t g_d;
  logic tick_done;

  assign tick_done = (g_q.tick == 24'(nm_cfg_pkg::GUARD_UNIT_CYCLES - 1));

  always_comb begin
    g_d = g_q;
    case (g_q.st)
      nm_cfg_pkg::GS_IDLE: begin
        if (enable_i && retry_i != 8'h00 && interval_i != 16'h0000) begin
          g_d.st = nm_cfg_pkg::GS_SEND;
          g_d.tries = 8'h00;
        end
      end
      nm_cfg_pkg::GS_SEND: begin
        g_d.st = nm_cfg_pkg::GS_WAIT;
        g_d.tries = g_q.tries + 8'h01;
        g_d.units = 16'h0000;
        g_d.tick = 24'h000000;
      end
      nm_cfg_pkg::GS_WAIT: begin
        if (reply_i) begin
          g_d.tries = 8'h00;
        end
        if (tick_done) begin
          g_d.tick = 24'h000000;
          g_d.units = g_q.units + 16'h0001;
          if (g_q.units + 16'h0001 >= interval_i) begin
            if (reply_i || g_q.tries == 8'h00) begin
              g_d.st = nm_cfg_pkg::GS_SEND;
            end else if (g_q.tries >= retry_i) begin
              g_d.st = nm_cfg_pkg::GS_FAIL;
            end else begin
              g_d.st = nm_cfg_pkg::GS_SEND;
            end
          end
        end else begin
          g_d.tick = g_q.tick + 24'h000001;
        end
      end
      nm_cfg_pkg::GS_FAIL: begin
        g_d.st = nm_cfg_pkg::GS_IDLE;
      end
      default: begin
        g_d.st = nm_cfg_pkg::GS_IDLE;
      end
    endcase
    if (!enable_i || retry_i == 8'h00 || interval_i == 16'h0000) begin
      g_d.st = nm_cfg_pkg::GS_IDLE;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      g_q <= '{st: nm_cfg_pkg::GS_IDLE, tries: 8'h00, units: 16'h0000, tick: 24'h000000};
    end else if (clk_en_i) begin
      g_q <= g_d;
    end
  end

  assign request_o = (g_q.st == nm_cfg_pkg::GS_SEND);
  assign fail_o = (g_q.st == nm_cfg_pkg::GS_FAIL);

endmodule
`default_nettype wire

// [core/nm_master.sv]
// Network master start-up configuration and slave management decisions.
// Assumes an object-dictionary access port (index, subindex, data) from firmware
// and a protocol engine that sends the commands this block requests.
`timescale 1ns/1ps
`default_nettype none
module nm_master (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // Object dictionary access
  input wire logic od_wr_i,
  input wire logic od_rd_i,
  input wire logic [15:0] od_index_i,
  input wire logic [7:0] od_sub_i,
  input wire logic [31:0] od_wdata_i,
  output logic [31:0] od_rdata_o,
  output logic od_ack_o,
  output logic od_err_o,
  // Network events
  input wire logic boot_done_i,
  input wire logic app_go_op_i,
  input wire logic ecs_event_i,
  input wire logic new_slave_i,
  input wire logic unreachable_i,
  input wire logic [6:0] event_node_i,
  // Guarding of the node in guard_node_i
  input wire logic guard_reply_i,
  input wire logic [6:0] guard_node_i,
  // Commands and status
  output logic master_mode_o,
  output logic self_operational_o,
  output logic start_all_o,
  output logic start_node_o,
  output logic stop_all_o,
  output logic reset_all_o,
  output logic boot_slave_o,
  output logic restore_slave_o,
  output logic app_notify_o,
  output logic guard_request_o,
  output logic guard_fail_o,
  output logic net_blocked_o,
  output logic [6:0] cmd_node_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [31:0] startup;
    logic loaded;
    logic self_op;
    logic start_all;
    logic start_node;
    logic stop_all;
    logic reset_all;
    logic boot_slave;
    logic restore;
    logic notify;
    logic blocked;
    logic [6:0] node;
    logic [31:0] rdata;
    logic ack;
    logic err;
  } master_st_t;

  master_st_t m_q;
  master_st_t m_d;

  // Per-node assignment words, index equals node ID
  logic [31:0] assign_q [128];
  logic [31:0] saved_startup;
  logic store_req;
  logic guard_fail;
  logic guard_req;
  logic [31:0] guard_word;
  logic [31:0] ev_word;
  logic is_master;
  logic su_start_all;
  logic su_no_auto_op;
  logic su_no_start;
  logic su_reset_all;
  logic su_stop_all;
  logic acc_startup;
  logic acc_entry;
  logic acc_count;
  logic acc_store;
  logic boot_ok;
  logic slave_up;
  logic slave_lost;
  logic ecs_any;
  logic [31:0] ecs_word;
  logic [6:0] ecs_node;

  function automatic logic sub_valid(input logic [7:0] sub);
    sub_valid = (sub != 8'h00) && (sub <= nm_cfg_pkg::NODE_COUNT);
  endfunction

  function automatic logic is_mandatory(input logic [31:0] w);
    is_mandatory = w[nm_cfg_pkg::SA_SLAVE] && w[nm_cfg_pkg::SA_MANDATORY];
  endfunction

  function automatic logic hits_entry(input logic [15:0] idx, input logic [7:0] sub);
    hits_entry = (idx == nm_cfg_pkg::IDX_ASSIGN) && sub_valid(sub);
  endfunction

  function automatic logic wants_boot(input logic [31:0] w);
    wants_boot = w[nm_cfg_pkg::SA_BOOT];
  endfunction

  function automatic logic [31:0] su_clean(input logic [31:0] w);
    su_clean = w & nm_cfg_pkg::STARTUP_MASK;
  endfunction

  assign is_master = m_q.startup[nm_cfg_pkg::SU_MASTER];
  assign ev_word = assign_q[event_node_i];
  assign guard_word = assign_q[guard_node_i];
  assign store_req = od_wr_i && od_index_i == nm_cfg_pkg::IDX_STORE && od_sub_i == nm_cfg_pkg::SUB_STORE_ALL
    && od_wdata_i == nm_cfg_pkg::STORE_SIGNATURE;

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  // Start-up controls, meaningful only in master operation
  assign su_start_all = m_q.startup[nm_cfg_pkg::SU_START_ALL];
  assign su_no_auto_op = m_q.startup[nm_cfg_pkg::SU_NO_AUTO_OP];
  assign su_no_start = m_q.startup[nm_cfg_pkg::SU_NO_START];
  assign su_reset_all = m_q.startup[nm_cfg_pkg::SU_RESET_ALL];
  assign su_stop_all = m_q.startup[nm_cfg_pkg::SU_STOP_ALL];

  // Object addressed by the access port
  assign acc_startup = (od_index_i == nm_cfg_pkg::IDX_STARTUP);
  assign acc_entry = hits_entry(od_index_i, od_sub_i);
  assign acc_count = (od_index_i == nm_cfg_pkg::IDX_ASSIGN) && (od_sub_i == 8'h00);
  assign acc_store = (od_index_i == nm_cfg_pkg::IDX_STORE);

  // Network events qualified by mode and by the node's entry; boot completion by mode and the blocked flag
  assign boot_ok = boot_done_i && is_master && !m_q.blocked;
  assign slave_up = new_slave_i && is_master && ev_word[nm_cfg_pkg::SA_SLAVE];
  assign slave_lost = unreachable_i && is_master && is_mandatory(ev_word);

  // Guard failure counts as an error control event of the guarded node
  assign ecs_any = (ecs_event_i || guard_fail) && is_master;
  assign ecs_word = guard_fail ? guard_word : ev_word;
  assign ecs_node = guard_fail ? guard_node_i : event_node_i;

  ////////////////////////////////////////////////////////////////////////////
  // Persistent copy and guarding

  nm_store u_store (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .store_i(store_req),
    .live_i(m_q.startup),
    .saved_o(saved_startup)
  );

  nm_guard u_guard (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .enable_i(is_master && guard_word[nm_cfg_pkg::SA_SLAVE]),
    .retry_i(guard_word[nm_cfg_pkg::SA_RETRY_LSB +: 8]),
    .interval_i(guard_word[nm_cfg_pkg::SA_INTERVAL_LSB +: 16]),
    .reply_i(guard_reply_i),
    .request_o(guard_req),
    .fail_o(guard_fail)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    m_d = m_q;
    m_d.start_all = 1'b0;
    m_d.start_node = 1'b0;
    m_d.stop_all = 1'b0;
    m_d.reset_all = 1'b0;
    m_d.boot_slave = 1'b0;
    m_d.restore = 1'b0;
    m_d.notify = 1'b0;
    m_d.ack = 1'b0;
    m_d.err = 1'b0;
    // Restored start-up word takes over one cycle after reset
    if (!m_q.loaded) begin
      m_d.loaded = 1'b1;
      m_d.startup = su_clean(saved_startup);
    end
    if (od_wr_i) begin
      m_d.ack = 1'b1;
      if (acc_startup) begin
        m_d.startup = su_clean(od_wdata_i);
      end else if (od_index_i == nm_cfg_pkg::IDX_ASSIGN) begin
        m_d.err = !acc_entry;
      end else if (!acc_store) begin
        m_d.err = 1'b1;
      end
    end else if (od_rd_i) begin
      m_d.ack = 1'b1;
      m_d.rdata = 32'h00000000;
      if (acc_startup) begin
        m_d.rdata = m_q.startup;
      end else if (acc_count) begin
        m_d.rdata = {24'h000000, nm_cfg_pkg::NODE_COUNT};
      end else if (acc_entry) begin
        m_d.rdata = assign_q[od_sub_i[6:0]];
      end else begin
        m_d.err = 1'b1;
      end
    end
    // Boot completion
    if (boot_ok) begin
      if (!su_no_start && su_start_all) begin
        m_d.start_all = 1'b1;
      end
      if (!su_no_auto_op) begin
        m_d.self_op = 1'b1;
      end
    end
    if (app_go_op_i && is_master) begin
      m_d.self_op = 1'b1;
    end
    // Configured slave reported reachable: start it if allowed
    if (slave_up) begin
      m_d.notify = 1'b1;
      m_d.node = event_node_i;
      if (wants_boot(ev_word)) begin
        m_d.boot_slave = 1'b1;
        m_d.restore = ev_word[nm_cfg_pkg::SA_RESTORE];
      end
      if (!su_no_start && !su_start_all) begin
        m_d.start_node = 1'b1;
      end
    end
    // Mandatory slave not contacted during boot
    if (slave_lost) begin
      m_d.blocked = 1'b1;
      m_d.notify = 1'b1;
      m_d.node = event_node_i;
    end
    // Error control event, from the network or from guarding
    if (ecs_any) begin
      m_d.notify = 1'b1;
      m_d.node = ecs_node;
      if (is_mandatory(ecs_word)) begin
        if (su_stop_all) begin
          m_d.stop_all = 1'b1;
          m_d.self_op = 1'b0;
        end else if (su_reset_all && !m_q.blocked) begin
          m_d.reset_all = 1'b1;
          m_d.self_op = 1'b0;
        end else if (wants_boot(ecs_word)) begin
          m_d.boot_slave = 1'b1;
        end
      end else if (wants_boot(ecs_word)) begin
        m_d.boot_slave = 1'b1;
      end
    end
    if (!is_master) begin
      m_d.self_op = 1'b0;
      m_d.blocked = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      m_q <= '0;
    end else if (clk_en_i) begin
      m_q <= m_d;
    end
  end

  // Assignment table, cleared by reset
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < 128; i++) begin
        assign_q[i] <= nm_cfg_pkg::ASSIGN_RESET;
      end
    end else if (clk_en_i && od_wr_i && acc_entry) begin
      assign_q[od_sub_i[6:0]] <= od_wdata_i & nm_cfg_pkg::ASSIGN_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign master_mode_o = is_master;
  assign self_operational_o = m_q.self_op;
  assign start_all_o = m_q.start_all;
  assign start_node_o = m_q.start_node;
  assign stop_all_o = m_q.stop_all;
  assign reset_all_o = m_q.reset_all;
  assign boot_slave_o = m_q.boot_slave;
  assign restore_slave_o = m_q.restore;
  assign app_notify_o = m_q.notify;
  assign guard_request_o = guard_req;
  assign guard_fail_o = guard_fail;
  assign net_blocked_o = m_q.blocked;
  assign cmd_node_o = m_q.node;
  assign od_rdata_o = m_q.rdata;
  assign od_ack_o = m_q.ack;
  assign od_err_o = m_q.err;

endmodule
`default_nettype wire

// [testbench/nm_master_chk.sv]
// Port checker of the network master start-up block.
// Assumes one clock domain; a shadow of the start-up word is kept from observed writes.
`timescale 1ns/1ps
`default_nettype none
module nm_master_chk (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // Access port
  input wire logic od_wr_i,
  input wire logic od_rd_i,
  input wire logic [15:0] od_index_i,
  input wire logic [31:0] od_wdata_i,
  input wire logic [31:0] od_rdata_o,
  input wire logic od_ack_o,
  input wire logic od_err_o,
  // Events and commands
  input wire logic boot_done_i,
  input wire logic app_go_op_i,
  input wire logic master_mode_o,
  input wire logic self_operational_o,
  input wire logic start_all_o,
  input wire logic start_node_o,
  input wire logic stop_all_o,
  input wire logic reset_all_o
);
  logic [31:0] su_q;
  logic known_q;
  logic su_wr;
  assign su_wr = clk_en_i && od_wr_i && (od_index_i == nm_cfg_pkg::IDX_STARTUP);
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      su_q <= 32'h0;
      known_q <= 1'b0;
    end else if (su_wr) begin
      su_q <= od_wdata_i & nm_cfg_pkg::STARTUP_MASK;
      known_q <= 1'b1;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  access_acked_a: assert property (clk_en_i && (od_wr_i || od_rd_i) |=> od_ack_o)
    else $error("access not acknowledged");
  ack_cause_a: assert property (od_ack_o |-> $past(od_wr_i || od_rd_i))
    else $error("ack without access");
  err_with_ack_a: assert property (od_err_o |-> od_ack_o)
    else $error("error without ack");
  mode_follows_a: assert property (known_q |-> master_mode_o == su_q[nm_cfg_pkg::SU_MASTER])
    else $error("master mode differs from start-up word");
  read_masked_a: assert property (
    od_ack_o && $past(od_rd_i && !od_wr_i && od_index_i == nm_cfg_pkg::IDX_STARTUP)
    |-> (od_rdata_o & ~nm_cfg_pkg::STARTUP_MASK) == 32'h0)
    else $error("reserved start-up bits read non-zero");
  no_start_a: assert property ((start_all_o || start_node_o) && known_q |-> !su_q[nm_cfg_pkg::SU_NO_START])
    else $error("start command while forbidden");
  start_all_cause_a: assert property (start_all_o |-> $past(boot_done_i) && (!known_q || su_q[1]))
    else $error("start all without cause");
  stop_all_cause_a: assert property (stop_all_o && known_q |-> su_q[6] && su_q[0])
    else $error("stop all without bit 6");
  reset_all_cause_a: assert property (reset_all_o && known_q |-> su_q[4] && !su_q[6])
    else $error("reset all against bits 4 and 6");
  op_entry_a: assert property ($rose(self_operational_o) && known_q |-> !su_q[2] || $past(app_go_op_i))
    else $error("operational entered without leave");
  cover property (start_all_o);
  cover property (stop_all_o);
  cover property (reset_all_o);
endmodule
`default_nettype wire

// [testbench/nm_slave_model.sv]
// Behavioural remote slave answering guarding requests.
// Assumes requests are one-cycle pulses; the reply follows two cycles later.
`timescale 1ns/1ps
`default_nettype none
module nm_slave_model (
  // Clock
  input wire logic ref_clk_i,
  // Guarding
  input wire logic answer_i,
  input wire logic request_i,
  output logic reply_o
);
  logic [1:0] dly_q = 2'h0;
  always_ff @(posedge ref_clk_i) begin
    dly_q <= {dly_q[0], request_i && answer_i};
  end
  assign reply_o = dly_q[1];
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench of the network master start-up block.
// Assumes the access port answers one cycle after a request.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic clk_en_i = 1'b1;
  logic od_wr_i = 1'b0;
  logic od_rd_i = 1'b0;
  logic [15:0] od_index_i = 16'h0;
  logic [7:0] od_sub_i = 8'h0;
  logic [31:0] od_wdata_i = 32'h0;
  logic [4:0] evt = 5'h0;
  logic [6:0] event_node_i = 7'h0;
  logic guard_reply_i;
  logic [31:0] od_rdata_o;
  logic od_ack_o, od_err_o, master_mode_o, self_operational_o, start_all_o, start_node_o;
  logic stop_all_o, reset_all_o, boot_slave_o, restore_slave_o, app_notify_o;
  logic guard_request_o, guard_fail_o, net_blocked_o;
  logic [6:0] cmd_node_o;
  logic ack_s, err_s;
  logic [31:0] rd_s;
  logic [6:0] cmd_s;
  logic [7:0] su_tab [3] = '{8'h03, 8'h0B, 8'h01};
  logic [6:0] boot_exp [3] = '{7'h40, 7'h00, 7'h00};
  int n_errors = 0;
  int comparisons = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  nm_master uut (.ref_clk_i, .sys_rst_i, .clk_en_i, .od_wr_i, .od_rd_i, .od_index_i, .od_sub_i,
    .od_wdata_i, .od_rdata_o, .od_ack_o, .od_err_o, .boot_done_i(evt[4]), .app_go_op_i(evt[3]),
    .ecs_event_i(evt[2]), .new_slave_i(evt[1]), .unreachable_i(evt[0]), .event_node_i, .guard_reply_i,
    .guard_node_i(7'h05), .master_mode_o, .self_operational_o, .start_all_o, .start_node_o, .stop_all_o,
    .reset_all_o, .boot_slave_o, .restore_slave_o, .app_notify_o, .guard_request_o, .guard_fail_o,
    .net_blocked_o, .cmd_node_o);
  nm_slave_model slave (.ref_clk_i, .answer_i(1'b1), .request_i(guard_request_o), .reply_o(guard_reply_i));
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic do_reset();
    sys_rst_i = 1'b1;
    repeat (16) @(posedge ref_clk_i);
    #1 sys_rst_i = 1'b0;
    @(posedge ref_clk_i);
    #1;
  endtask
  task automatic acc(input logic w, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d);
    od_wr_i = w;
    od_rd_i = !w;
    od_index_i = idx;
    od_sub_i = sub;
    od_wdata_i = d;
    @(posedge ref_clk_i);
    #1;
    {ack_s, err_s, rd_s} = {od_ack_o, od_err_o, od_rdata_o};
    od_wr_i = 1'b0;
    od_rd_i = 1'b0;
    @(posedge ref_clk_i);
    #1;
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d, input logic e);
    acc(1'b1, idx, sub, d);
    check({31'h0, ack_s}, 32'h1);
    check({31'h0, err_s}, {31'h0, e});
  endtask
  task automatic rd(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] exp);
    acc(1'b0, idx, sub, 32'h0);
    check(rd_s, exp);
  endtask
  task automatic pulse(input logic [4:0] e, input logic [6:0] node);
    evt = e;
    event_node_i = node;
    @(posedge ref_clk_i);
    #1;
    cmd_s = {start_all_o, start_node_o, stop_all_o, reset_all_o, boot_slave_o, restore_slave_o, app_notify_o};
    evt = 5'h0;
    @(posedge ref_clk_i);
    #1;
  endtask
  task automatic complete_run();
    if (n_errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #300000;
    n_errors++;
    complete_run();
  end
  initial begin
    do_reset();
    wr(16'h1F80, 8'h00, 32'h0, 1'b0);
    wr(16'h1010, 8'h01, 32'h65766173, 1'b0);
    rd(16'h1F80, 8'h00, 32'h0);
    wr(16'h1F80, 8'h00, 32'h05, 1'b0);
    pulse(5'h10, 7'h00);
    check({31'h0, self_operational_o}, 32'h0);
    pulse(5'h08, 7'h00);
    check({31'h0, self_operational_o}, 32'h1);
    wr(16'h1F80, 8'h00, 32'hFFFFFFFF, 1'b0);
    rd(16'h1F80, 8'h00, 32'h5F);
    wr(16'h1F80, 8'h00, 32'h01, 1'b0);
    wr(16'h1010, 8'h01, 32'h65766173, 1'b0);
    wr(16'h1F80, 8'h00, 32'h00, 1'b0);
    check({31'h0, master_mode_o}, 32'h0);
    do_reset();
    check({31'h0, master_mode_o}, 32'h1);
    wr(16'h1F81, 8'h05, 32'h01F403FF, 1'b0);
    check({31'h0, guard_request_o}, 32'h1);
    wr(16'h1F81, 8'h06, 32'h01, 1'b0);
    rd(16'h1F81, 8'h05, 32'h01F4038D);
    rd(16'h1F81, 8'h06, 32'h01);
    wr(16'h1F81, 8'h00, 32'h01, 1'b1);
    wr(16'h1F82, 8'h01, 32'h01, 1'b1);
    for (int i = 0; i < 3; i++) begin
      wr(16'h1F80, 8'h00, {24'h0, su_tab[i]}, 1'b0);
      pulse(5'h10, 7'h00);
      check({25'h0, cmd_s & 7'h40}, {25'h0, boot_exp[i]});
    end
    wr(16'h1F81, 8'h07, 32'h85, 1'b0);
    wr(16'h1F81, 8'h08, 32'h01, 1'b0);
    pulse(5'h02, 7'h07);
    check({25'h0, cmd_s & 7'h07}, 32'h07);
    check({25'h0, cmd_node_o}, 32'h07);
    pulse(5'h02, 7'h08);
    check({25'h0, cmd_s & 7'h07}, 32'h01);
    wr(16'h1F81, 8'h05, 32'h09, 1'b0);
    wr(16'h1F80, 8'h00, 32'h01, 1'b0);
    pulse(5'h04, 7'h05);
    check({25'h0, cmd_s & 7'h18}, 32'h00);
    wr(16'h1F80, 8'h00, 32'h51, 1'b0);
    pulse(5'h04, 7'h05);
    check({25'h0, cmd_s & 7'h18}, 32'h10);
    wr(16'h1F80, 8'h00, 32'h11, 1'b0);
    pulse(5'h04, 7'h06);
    check({25'h0, cmd_s & 7'h18}, 32'h00);
    pulse(5'h04, 7'h05);
    check({25'h0, cmd_s & 7'h18}, 32'h08);
    wr(16'h1F81, 8'h05, 32'h09, 1'b0);
    wr(16'h1F80, 8'h00, 32'h03, 1'b0);
    pulse(5'h01, 7'h05);
    check({31'h0, net_blocked_o}, 32'h1);
    pulse(5'h10, 7'h00);
    check({25'h0, cmd_s & 7'h40}, 32'h00);
    clk_en_i = 1'b0;
    acc(1'b1, 16'h1F80, 8'h00, 32'h00);
    clk_en_i = 1'b1;
    check({31'h0, ack_s}, 32'h0);
    check({31'h0, master_mode_o}, 32'h1);
    complete_run();
  end
endmodule
bind nm_master nm_master_chk chk (.ref_clk_i, .sys_rst_i, .clk_en_i, .od_wr_i, .od_rd_i, .od_index_i,
  .od_wdata_i, .od_rdata_o, .od_ack_o, .od_err_o, .boot_done_i, .app_go_op_i, .master_mode_o,
  .self_operational_o, .start_all_o, .start_node_o, .stop_all_o, .reset_all_o);
`default_nettype wire
